// ===== common/cursor_params.svh
// Constants for the hardware pointer overlay.
// Assumes inclusion by bare name from the design files.
`ifndef CURSOR_PARAMS_SVH
`define CURSOR_PARAMS_SVH

// ==========================================================
// Sequencer index decode
`define CUR_IDX_POS_MASK 5'h1f
`define CUR_IDX_X_LOW 5'h10
`define CUR_IDX_Y_LOW 5'h11
`define CUR_IDX_ATTR 8'h12
`define CUR_IDX_OFFSET 8'h13
`define CUR_ATTR_ENABLE_BIT 0

// ==========================================================
// Geometry and fetch address layout
`define CUR_SIZE 11'h020
`define CUR_ADDR_TOP 4'hf
`define CUR_ADDR_GAP 2'h0

// ==========================================================
// Pixel codes {opaque, invert} and palette slots
`define CUR_CODE_TRANSP 2'h0
`define CUR_CODE_INVERT 2'h1
`define CUR_CODE_COLOR0 2'h2
`define CUR_CODE_COLOR1 2'h3
`define CUR_COLOR0_INDEX 9'h100
`define CUR_COLOR1_INDEX 9'h101

`endif

// ===== common/cursor_pkg.sv
// Types for the hardware pointer overlay.
// Assumes nothing beyond a SystemVerilog compiler.
package cursor_pkg;

	// ==========================================================
	// Fetch sequencer
	typedef enum logic [2:0] {
		F_IDLE = 3'b001,
		F_P0 = 3'b010,
		F_P1 = 3'b100
	} fetch_state_t;

	// ==========================================================
	// Whole state of the overlay apart from the line store bytes
	typedef struct packed {
		logic enable;
		logic [10:0] x_shadow;
		logic [10:0] y_shadow;
		logic [10:0] x_live;
		logic [10:0] y_live;
		logic pend;
		logic [5:0] offset;
		logic vsync_q;
		fetch_state_t fst;
		logic line_valid;
		logic req;
		logic [17:0] addr;
		logic s1_hit;
		logic [2:0] s1_bit;
		logic [7:0] s1_video;
		logic [8:0] out_index;
	} ovl_state_t;

endpackage

// ===== common/cursor_store_if.sv
// Link between the overlay and its line store.
// Assumes both ends run on the same clock.
interface cursor_store_if;
	logic wr;
	logic wplane;
	logic [31:0] wdata;
	logic [1:0] raddr;
	logic [15:0] rdata;

	modport writer (output wr, output wplane, output wdata, output raddr,
		input rdata);
	modport store (input wr, input wplane, input wdata, input raddr,
		output rdata);
endinterface

// ===== logic/cursor_line_store.sv
// Holds one cursor scanline: one byte per map for each plane.
// Assumes the overlay writes only during blanking.
module cursor_line_store (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clk_en,
	cursor_store_if.store port
);
	logic [7:0] plane0 [4];
	logic [7:0] plane1 [4];
	logic [15:0] rdata;

	// ==========================================================
	// Per-map byte lanes
	for (genvar m = 0; m < 4; m++) begin : g_map
		always_ff @(posedge clock) begin
			if (!reset_n) begin
				plane0[m] <= 8'h00;
				plane1[m] <= 8'h00;
			end else if (clk_en && port.wr) begin
				if (port.wplane)
					plane1[m] <= port.wdata[8*m +: 8];
				else
					plane0[m] <= port.wdata[8*m +: 8];
			end
		end
	end

	// ==========================================================
	// Registered read
	always_ff @(posedge clock) begin
		if (!reset_n)
			rdata <= 16'h0000;
		else if (clk_en)
			rdata <= {plane1[port.raddr], plane0[port.raddr]};
	end

	assign port.rdata = rdata;
endmodule

// ===== logic/hardware_cursor_overlay.sv
// Two-plane 32x32 pointer overlay on the final video pixel stream.
// Assumes timing inputs, register writes and memory answers all come
// from logic on the same dot clock.
//
// Contract
// - Overlay works in 16-colour planar and 256-colour packed modes.
// - Pointer is 32x32 pixels; plane 0 inverts, plane 1 is opaque.
// - Code 00 transparent, 01 inverted, 10 colour 0, 11 colour 1.
// - Inversion acts on screen data after every other transformation.
// - Cursor colours come from two extra palette entries.
// - Position is the upper-left corner in active-area pixels/scanlines.
// - New position takes effect at vsync after the Y register write.
// - Position zero is the first pixel of the top active scanline.
// - Pattern data lives in the top 16K of display memory.
// - Pattern offset register picks one of 64 256-byte patterns.
// - Per map, bytes 0-31 plane 0, bytes 128-159 plane 1.
// - Map 0 byte is shown first; bit 7 is the leftmost pixel.
// - Cursor fetch takes the refresh slot on cursor lines.
// - Each line fetch is two reads, plane 0 then plane 1, all maps.
// - Fetch address: 17:14 ones, 13:8 offset, bit 7 plane select.
// - Cursor is off after reset; attribute bit 0 enables it.
`include "cursor_params.svh"

module hardware_cursor_overlay
	import cursor_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic [7:0] reg_index,
	input wire logic [7:0] reg_wdata,
	input wire logic vsync,
	input wire logic active,
	input wire logic [10:0] pix_x,
	input wire logic [10:0] pix_y,
	input wire logic [7:0] video_in,
	input wire logic refresh_slot,
	input wire logic [10:0] next_line,
	output logic refresh_skip,
	output logic mem_req,
	output logic [17:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic [8:0] dac_index
);
	ovl_state_t st;
	ovl_state_t next_st;
	logic vsync_rise;
	logic line_hit;
	logic [10:0] row_full;
	logic [10:0] col_full;
	logic pix_hit;
	logic [1:0] code;
	logic [2:0] bit_pos;

	cursor_store_if store_bus ();

	cursor_line_store u_store (
		.clock(clock),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.port(store_bus)
	);

	// ==========================================================
	// Window decode
	always_comb begin
		vsync_rise = vsync && !st.vsync_q;
		row_full = next_line - st.y_live;
		line_hit = st.enable && (next_line >= st.y_live) &&
			(row_full < `CUR_SIZE);
		col_full = pix_x - st.x_live;
		pix_hit = st.enable && st.line_valid && active &&
			(pix_x >= st.x_live) && (col_full < `CUR_SIZE);
		bit_pos = 3'h7 - st.s1_bit;
		code = {store_bus.rdata[8 + bit_pos],
			store_bus.rdata[bit_pos]};
	end

	// ==========================================================
	// Refresh slot steal and store link
	always_comb begin
		refresh_skip = refresh_slot && line_hit &&
			(st.fst == F_IDLE);
		store_bus.wr = mem_ack && (st.fst != F_IDLE);
		store_bus.wplane = (st.fst == F_P1);
		store_bus.wdata = mem_rdata;
		store_bus.raddr = col_full[4:3];
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		next_st.vsync_q = vsync;
		// A Y write in the vsync cycle stays pending for the next vsync
		if (vsync_rise && st.pend) begin
			next_st.x_live = st.x_shadow;
			next_st.y_live = st.y_shadow;
			next_st.pend = 1'b0;
		end
		if (reg_wr) begin
			if (reg_index[4:0] == `CUR_IDX_X_LOW)
				next_st.x_shadow = {reg_index[7:5], reg_wdata};
			if (reg_index[4:0] == `CUR_IDX_Y_LOW) begin
				next_st.y_shadow = {reg_index[7:5], reg_wdata};
				next_st.pend = 1'b1;
			end
			if (reg_index == `CUR_IDX_ATTR)
				next_st.enable = reg_wdata[`CUR_ATTR_ENABLE_BIT];
			if (reg_index == `CUR_IDX_OFFSET)
				next_st.offset = reg_wdata[5:0];
		end
		case (st.fst)
			F_IDLE: begin
				if (refresh_slot) begin
					next_st.line_valid = 1'b0;
					if (line_hit) begin
						next_st.fst = F_P0;
						next_st.req = 1'b1;
						next_st.addr = {`CUR_ADDR_TOP, st.offset, 1'b0,
							`CUR_ADDR_GAP, row_full[4:0]};
					end
				end
			end
			F_P0: begin
				if (mem_ack) begin
					next_st.fst = F_P1;
					next_st.addr[7] = 1'b1;
				end
			end
			F_P1: begin
				if (mem_ack) begin
					next_st.fst = F_IDLE;
					next_st.req = 1'b0;
					next_st.line_valid = 1'b1;
				end
			end
			default: begin
				next_st.fst = F_IDLE;
				next_st.req = 1'b0;
			end
		endcase
		// Pixel pipeline: stage 1 aligns with the store read
		next_st.s1_hit = pix_hit;
		next_st.s1_bit = col_full[2:0];
		next_st.s1_video = video_in;
		if (!st.s1_hit)
			next_st.out_index = {1'b0, st.s1_video};
		else begin
			case (code)
				`CUR_CODE_TRANSP: next_st.out_index = {1'b0, st.s1_video};
				`CUR_CODE_INVERT: next_st.out_index = {1'b0, ~st.s1_video};
				`CUR_CODE_COLOR0: next_st.out_index = `CUR_COLOR0_INDEX;
				`CUR_CODE_COLOR1: next_st.out_index = `CUR_COLOR1_INDEX;
				default: next_st.out_index = {1'b0, st.s1_video};
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st <= '0;
			st.fst <= F_IDLE;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign mem_req = st.req;
	assign mem_addr = st.addr;
	assign dac_index = st.out_index;

	// ==========================================================
	// Checks
	property p_transparent;
		@(posedge clock) disable iff (!reset_n)
		clk_en && (!st.s1_hit || code == `CUR_CODE_TRANSP) |=>
			dac_index == {1'b0, $past(st.s1_video)};
	endproperty
	a_transparent: assert property (p_transparent)
		else $error("screen pixel not passed through");

	property p_invert;
		@(posedge clock) disable iff (!reset_n)
		clk_en && st.s1_hit && code == `CUR_CODE_INVERT |=>
			dac_index == {1'b0, ~$past(st.s1_video)};
	endproperty
	a_invert: assert property (p_invert)
		else $error("inverted pixel wrong");

	property p_color0;
		@(posedge clock) disable iff (!reset_n)
		clk_en && st.s1_hit && code == `CUR_CODE_COLOR0 |=>
			dac_index == `CUR_COLOR0_INDEX;
	endproperty
	a_color0: assert property (p_color0)
		else $error("cursor colour 0 entry not selected");

	property p_color1;
		@(posedge clock) disable iff (!reset_n)
		clk_en && st.s1_hit && code == `CUR_CODE_COLOR1 |=>
			dac_index == `CUR_COLOR1_INDEX;
	endproperty
	a_color1: assert property (p_color1)
		else $error("cursor colour 1 entry not selected");

	property p_addr;
		@(posedge clock) disable iff (!reset_n)
		mem_req |-> mem_addr[17:14] == `CUR_ADDR_TOP &&
			mem_addr[7] == (st.fst == F_P1);
	endproperty
	a_addr: assert property (p_addr)
		else $error("fetch address layout wrong");

	property p_two_reads;
		@(posedge clock) disable iff (!reset_n)
		clk_en && st.fst == F_P0 && mem_ack |=>
			st.fst == F_P1 && mem_req;
	endproperty
	a_two_reads: assert property (p_two_reads)
		else $error("plane 1 read did not follow plane 0");

	property p_hold_pos;
		@(posedge clock) disable iff (!reset_n)
		clk_en && !vsync_rise |=> $stable(st.y_live) && $stable(st.x_live);
	endproperty
	a_hold_pos: assert property (p_hold_pos)
		else $error("position changed outside vsync");

	property p_attr;
		@(posedge clock) disable iff (!reset_n)
		clk_en && reg_wr && reg_index == `CUR_IDX_ATTR |=>
			st.enable == $past(reg_wdata[`CUR_ATTR_ENABLE_BIT]);
	endproperty
	a_attr: assert property (p_attr)
		else $error("enable bit not taken");

	property p_refresh;
		@(posedge clock) disable iff (!reset_n)
		refresh_skip |-> refresh_slot && st.enable && !st.req;
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("refresh slot taken without cause");

	// ==========================================================
	// Fetch sequencing, disable and position update checks
	property p_req_hold;
		@(posedge clock) disable iff (!reset_n)
		clk_en && mem_req && !mem_ack |=>
			mem_req && $stable(mem_addr);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("read request dropped or moved before its answer");

	property p_fetch_addr;
		@(posedge clock) disable iff (!reset_n)
		clk_en && refresh_skip |=> mem_req && !mem_addr[7] &&
			mem_addr[13:8] == $past(st.offset) &&
			mem_addr[6:5] == `CUR_ADDR_GAP &&
			mem_addr[4:0] == $past(row_full[4:0]);
	endproperty
	a_fetch_addr: assert property (p_fetch_addr)
		else $error("first read of a line has wrong pattern or row");

	property p_line_done;
		@(posedge clock) disable iff (!reset_n)
		clk_en && st.fst == F_P1 && mem_ack |=>
			st.fst == F_IDLE && st.line_valid && !mem_req;
	endproperty
	a_line_done: assert property (p_line_done)
		else $error("line not ready after plane 1 read");

	property p_slot_clear;
		@(posedge clock) disable iff (!reset_n)
		clk_en && refresh_slot && st.fst == F_IDLE |=> !st.line_valid;
	endproperty
	a_slot_clear: assert property (p_slot_clear)
		else $error("stale cursor line kept across a refresh slot");

	property p_off_pass;
		@(posedge clock) disable iff (!reset_n)
		clk_en && !st.enable |=> !st.s1_hit;
	endproperty
	a_off_pass: assert property (p_off_pass)
		else $error("cursor pixel used while disabled");

	property p_pend;
		@(posedge clock) disable iff (!reset_n)
		clk_en && reg_wr && reg_index[4:0] == `CUR_IDX_Y_LOW |=>
			st.pend;
	endproperty
	a_pend: assert property (p_pend)
		else $error("Y write did not arm the position update");

	property p_apply;
		@(posedge clock) disable iff (!reset_n)
		clk_en && vsync_rise && st.pend |=>
			st.x_live == $past(st.x_shadow) &&
			st.y_live == $past(st.y_shadow);
	endproperty
	a_apply: assert property (p_apply)
		else $error("pending position not applied at vsync");
endmodule

// ===== testbench/cursor_mem_model.sv
// Behavioural display memory answering cursor pattern reads.
// Assumes the bench preloads mem and drives the answer latency.
module cursor_mem_model (
	input wire logic clock,
	input wire logic mem_req,
	input wire logic [17:0] mem_addr,
	input wire logic [1:0] lat,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [0:4095];
	int cnt;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
		cnt = 0;
	end
	// ==========================================================
	// Answer after lat idle cycles; data bus toggles when not valid
	always @(posedge clock) begin
		if (mem_ack) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_req && cnt >= lat) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[{mem_addr[13:8], mem_addr[7], mem_addr[4:0]}];
			cnt <= 0;
		end else begin
			cnt <= mem_req ? cnt + 1 : 0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

// ===== testbench/tb_hardware_cursor_overlay.sv
// Self-checking bench for the pointer overlay with a line-level model.
// Assumes cursor_mem_model stands in for display memory.
`include "cursor_params.svh"
module tb_hardware_cursor_overlay;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, reset_n, reg_wr, vsync, active, refresh_slot;
	logic [7:0] reg_index, reg_wdata, video_in;
	logic [10:0] pix_x, pix_y, next_line;
	logic refresh_skip, mem_req, mem_ack;
	logic [17:0] mem_addr;
	logic [31:0] mem_rdata;
	logic [8:0] dac_index;
	logic [1:0] lat;
	logic [8:0] q[$];
	int errors, n_checks, en, px, py, nx, ny, off;

	hardware_cursor_overlay u_dut (.clock(clock), .reset_n(reset_n),
		.clk_en(1'b1), .reg_wr(reg_wr), .reg_index(reg_index),
		.reg_wdata(reg_wdata), .vsync(vsync), .active(active),
		.pix_x(pix_x), .pix_y(pix_y), .video_in(video_in),
		.refresh_slot(refresh_slot), .next_line(next_line),
		.refresh_skip(refresh_skip), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.dac_index(dac_index));
	cursor_mem_model u_mem (.clock(clock), .mem_req(mem_req),
		.mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	// ==========================================================
	// Helpers
	task automatic print_verdict;
		$display("Checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step;
		@(posedge clock);
		#1;
	endtask
	task automatic wr(logic [7:0] idx, logic [7:0] data);
		step;
		reg_wr = 1'b1;
		reg_index = idx;
		reg_wdata = data;
		step;
		reg_wr = 1'b0;
	endtask
	task automatic set_pos(int x, int y, int o);
		wr(8'h10, x[7:0]);
		wr(8'h11, y[7:0]);
		wr(`CUR_IDX_OFFSET, o[7:0]);
		nx = x;
		ny = y;
		off = o;
	endtask
	task automatic vs;
		step;
		vsync = 1'b1;
		repeat (2) step;
		vsync = 1'b0;
		px = nx;
		py = ny;
	endtask
	function automatic logic [8:0] expect_pix(int x, int ln, logic [7:0] v);
		int c, b;
		logic [31:0] w0, w1;
		c = x - px;
		if (en == 0 || c < 0 || c > 31 || ln < py || ln > py + 31)
			return {1'b0, v};
		w0 = u_mem.mem[{off[5:0], 1'b0, 5'(ln - py)}];
		w1 = u_mem.mem[{off[5:0], 1'b1, 5'(ln - py)}];
		b = 8 * (c / 8) + 7 - c % 8;
		case ({w1[b], w0[b]})
			`CUR_CODE_TRANSP: return {1'b0, v};
			`CUR_CODE_INVERT: return {1'b0, ~v};
			`CUR_CODE_COLOR0: return `CUR_COLOR0_INDEX;
			default: return `CUR_COLOR1_INDEX;
		endcase
	endfunction

	// ==========================================================
	// One scanline: refresh slot, fetch, then 52 active pixels
	task automatic run_line(int ln);
		int k, hit;
		logic [7:0] v;
		hit = (en != 0 && ln >= py && ln < py + 32);
		step;
		lat = 2'($urandom_range(3));
		next_line = 11'(ln);
		refresh_slot = 1'b1;
		#1 check("refresh_skip", hit, refresh_skip);
		step;
		refresh_slot = 1'b0;
		k = 0;
		repeat (20) begin
			if (mem_req === 1'b1 && mem_ack === 1'b1) begin
				check("mem_addr", {4'hf, 6'(off), 1'(k), 2'h0, 5'(ln - py)},
					mem_addr);
				k++;
			end
			step;
		end
		check("reads", 2 * hit, k);
		for (int x = 0; x < 52; x++) begin
			if (q.size() == 2) check("dac_index", q.pop_front(), dac_index);
			v = 8'($urandom);
			active = 1'b1;
			pix_x = 11'(x);
			pix_y = 11'(ln);
			video_in = v;
			q.push_back(expect_pix(x, ln, v));
			step;
		end
		active = 1'b0;
		repeat (2) begin
			check("dac_index", q.pop_front(), dac_index);
			step;
		end
	endtask

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		#1000000;
		errors++;
		print_verdict;
	end
	initial begin
		void'($urandom(32'h65c9da0b));
		{reset_n, reg_wr, vsync, active, refresh_slot} = 5'h00;
		{reg_index, reg_wdata, video_in, lat} = 26'h0;
		{pix_x, pix_y, next_line} = 33'h0;
		{en, px, py, nx, ny, off} = '0;
		for (int i = 0; i < 4096; i++) u_mem.mem[i] = $urandom;
		repeat (2) step;
		reset_n = 1'b1;
		check("dac_index", 0, dac_index);
		check("mem_req", 0, mem_req);
		run_line(0);
		wr(`CUR_IDX_ATTR, 8'h01);
		en = 1;
		set_pos(0, 0, $urandom_range(3));
		vs;
		for (int l = 0; l < 34; l++) run_line(l);
		set_pos($urandom_range(16), 1 + $urandom_range(6), $urandom_range(3));
		run_line(0);
		vs;
		for (int l = 0; l < py + 34; l++) run_line(l);
		wr(`CUR_IDX_ATTR, 8'h00);
		en = 0;
		run_line(py);
		print_verdict;
	end
endmodule
